// ---- adc_pwm_trigger_sync_test.sv ----
// self-checking bench for the trigger and synchronisation fabric
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module adc_pwm_trigger_sync_test import ats_pkg::*;;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic CLK, RESET_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
	logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, WG_TRANS_EN;
	logic CARRIER_PAUSE_PIN, T0_PAUSE, T1_PAUSE, slow_sel;
	logic [ATS_ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB, WG_CYCLE_OUT, T0_MATCH, T1_MATCH;
	logic [3:0] WG_SYNC_IN, WG_CARRIER;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, EXT_START_PIN, CONV_EOC_CHAIN;
	logic [1:0] CONV_START, T0_CAPTURE, T1_CAPTURE;
	int err_count = 0;
	int check_count = 0;
	ats_trigger_fabric #(.N_WG(4)) uut (.CLK(CLK), .RESET_N(RESET_N),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .EXT_START_PIN(EXT_START_PIN),
		.CONV_EOC_CHAIN(CONV_EOC_CHAIN), .WG_CYCLE_OUT(WG_CYCLE_OUT),
		.T0_MATCH(T0_MATCH), .T1_MATCH(T1_MATCH),
		.CARRIER_PAUSE_PIN(CARRIER_PAUSE_PIN), .CONV_START(CONV_START),
		.WG_SYNC_IN(WG_SYNC_IN), .WG_TRANS_EN(WG_TRANS_EN),
		.WG_CARRIER(WG_CARRIER), .T0_PAUSE(T0_PAUSE), .T1_PAUSE(T1_PAUSE),
		.T0_CAPTURE(T0_CAPTURE), .T1_CAPTURE(T1_CAPTURE));
	ats_far_model far (.clk(CLK), .rst_n(RESET_N), .slow(slow_sel),
		.conv_start(CONV_START), .eoc_chain(CONV_EOC_CHAIN));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic results();
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1 && n < 50);
		S_AXI_BREADY <= 1'b0;
		`CHK("bresp", r, S_AXI_BRESP)
		if (n >= 50) begin
			err_count++;
			results();
		end
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1 && n < 50);
		S_AXI_RREADY <= 1'b0;
		`CHK("rdata", d, S_AXI_RDATA)
		`CHK("rresp", r, S_AXI_RRESP)
		if (n >= 50) begin
			err_count++;
			results();
		end
	endtask
	// 99 means no start expected on that converter
	task automatic watch(input int l0, input int l1);
		for (int i = 1; i <= 8; i++) begin
			@(posedge CLK);
			#1;
			`CHK("start0", (i == l0), CONV_START[0])
			`CHK("start1", (i == l1), CONV_START[1])
			`CHK("cap0", {2{i == l0 + 1}}, {T0_CAPTURE[0], T1_CAPTURE[0]})
			`CHK("cap1", {2{i == l1 + 1}}, {T0_CAPTURE[1], T1_CAPTURE[1]})
		end
	endtask
	task automatic idle();
		@(posedge CLK);
		T0_MATCH <= 4'h0;
		T1_MATCH <= 4'h0;
		WG_CYCLE_OUT <= 4'h0;
		EXT_START_PIN <= 2'h0;
		CARRIER_PAUSE_PIN <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		axr(ATS_CTRL_OFS, 32'h0, ATS_RESP_OKAY);
		axw(8'h10, 32'h3FF, ATS_RESP_SLVERR);
		axr(8'h14, 32'h0, ATS_RESP_SLVERR);
		axw(ATS_CNT0_OFS, 32'hFFFF, ATS_RESP_OKAY);
		axr(ATS_CNT0_OFS, 32'h0, ATS_RESP_OKAY);
		// upper lane only: the enables in the low lane must stay clear
		S_AXI_WSTRB <= 4'h2;
		axw(ATS_CTRL_OFS, 32'h3FF, ATS_RESP_OKAY);
		axr(ATS_CTRL_OFS, 32'h300, ATS_RESP_OKAY);
		S_AXI_WSTRB <= 4'hF;
	endtask
	task automatic t_route();
		@(posedge CLK);
		T0_MATCH <= 4'h8;
		T1_MATCH <= 4'h5;
		WG_CYCLE_OUT <= 4'h3;
		CARRIER_PAUSE_PIN <= 1'b1;
		@(posedge CLK);
		#1;
		`CHK("sync", 4'h7, WG_SYNC_IN)
		`CHK("trans", 1'b1, WG_TRANS_EN)
		`CHK("carrier", 4'h5, WG_CARRIER)
		`CHK("t1pause", 1'b1, T1_PAUSE)
		`CHK("t0pause", 1'b0, T0_PAUSE)
		idle();
		`CHK("t0pause", 1'b1, T0_PAUSE)
		`CHK("t1pause", 1'b0, T1_PAUSE)
	endtask
	task automatic t_timer0();
		axw(ATS_CTRL_OFS, 32'h8, ATS_RESP_OKAY);
		@(posedge CLK);
		T0_MATCH <= 4'h2;
		watch(3, 99);
		axr(ATS_STAT_OFS, 32'h8, ATS_RESP_OKAY);
		axr(ATS_CNT0_OFS, 32'h1, ATS_RESP_OKAY);
		idle();
	endtask
	task automatic t_chain(input logic s);
		axw(ATS_CTRL_OFS, 32'h28, ATS_RESP_OKAY);
		@(posedge CLK);
		slow_sel <= s;
		T0_MATCH <= 4'h1;
		watch(3, s ? 7 : 5);
		idle();
	endtask
	task automatic t_pin();
		axw(ATS_CTRL_OFS, 32'h211, ATS_RESP_OKAY);
		axr(ATS_CTRL_OFS, 32'h211, ATS_RESP_OKAY);
		@(posedge CLK);
		EXT_START_PIN <= 2'h3;
		watch(3, 99);
		@(posedge CLK);
		EXT_START_PIN <= 2'h0;
		watch(99, 3);
	endtask
	task automatic t_gen();
		axw(ATS_CTRL_OFS, 32'h44, ATS_RESP_OKAY);
		@(posedge CLK);
		WG_CYCLE_OUT <= 4'h8;
		watch(3, 3);
		axr(ATS_STAT_OFS, 32'h44, ATS_RESP_OKAY);
		axr(ATS_CNT0_OFS, 32'h5, ATS_RESP_OKAY);
		axr(ATS_CNT1_OFS, 32'h4, ATS_RESP_OKAY);
		idle();
	endtask
	// ----------------------------------------
	// clock, reset and main sequence
	// ----------------------------------------
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	initial begin
		{RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h0;
		{S_AXI_ARVALID, S_AXI_RREADY, CARRIER_PAUSE_PIN, slow_sel} = 4'h0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
		S_AXI_WSTRB = 4'hF;
		{WG_CYCLE_OUT, T0_MATCH, T1_MATCH, EXT_START_PIN} = 14'h0;
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		t_regs();
		t_route();
		t_timer0();
		t_chain(1'b0);
		t_chain(1'b1);
		t_pin();
		t_gen();
		results();
	end
endmodule
`undef CHK
`default_nettype wire

// ---- ats_far_model.sv ----
// far-side model: converters answer every start with an end-of-conversion pulse
`timescale 1ns/1ps
`default_nettype none
module ats_far_model import ats_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [ATS_NCONV-1:0] conv_start,
	output logic [ATS_NCONV-1:0] eoc_chain
);
	// ----------------------------------------
	// conversion latency line
	// ----------------------------------------
	logic [2:0] sh0_reg;
	logic [2:0] sh1_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh0_reg <= 3'h0;
			sh1_reg <= 3'h0;
		end else begin
			sh0_reg <= {sh0_reg[1:0], conv_start[0]};
			sh1_reg <= {sh1_reg[1:0], conv_start[1]};
		end
	end
	// slow mode stretches conversion so late chain starts get exercised
	assign eoc_chain[0] = slow ? sh0_reg[2] : sh0_reg[0];
	assign eoc_chain[1] = slow ? sh1_reg[2] : sh1_reg[0];
endmodule
`default_nettype wire

// ---- ats_pkg.sv ----
// constants shared by the trigger and synchronisation fabric
package ats_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ATS_ADDR_W = 8;
	localparam logic [ATS_ADDR_W-1:0] ATS_CTRL_OFS = 8'h00;
	localparam logic [ATS_ADDR_W-1:0] ATS_STAT_OFS = 8'h04;
	localparam logic [ATS_ADDR_W-1:0] ATS_CNT0_OFS = 8'h08;
	localparam logic [ATS_ADDR_W-1:0] ATS_CNT1_OFS = 8'h0C;
	localparam logic [ATS_ADDR_W-1:0] ATS_MAP_END = 8'h10;

	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	localparam int ATS_CTRL_W = 10;
	localparam logic [ATS_CTRL_W-1:0] ATS_CTRL_RST = 10'h000;
	localparam int ATS_EN_LSB = 0;
	localparam int ATS_FALL_LSB = 8;
	localparam int ATS_LANE0_W = 8;
	localparam int ATS_LANE1_W = 2;

	// ----------------------------------------
	// start sources of each converter
	// ----------------------------------------
	localparam int ATS_NSRC = 4;
	localparam int ATS_SRC_PIN = 0;
	localparam int ATS_SRC_CHAIN = 1;
	localparam int ATS_SRC_WG = 2;
	localparam int ATS_SRC_T0 = 3;
	localparam int ATS_NCONV = 2;

	// timer-0 match output that starts the first generator
	localparam int ATS_T0_WG_MATCH = 3;
	localparam int ATS_NT0_MATCH = 4;

	// ----------------------------------------
	// misc
	// ----------------------------------------
	localparam int ATS_CNT_W = 16;
	localparam logic [ATS_CNT_W-1:0] ATS_CNT_ONE = 16'h0001;
	localparam logic [1:0] ATS_RESP_OKAY = 2'h0;
	localparam logic [1:0] ATS_RESP_SLVERR = 2'h2;
	localparam logic [31:0] ATS_WORD_ZERO = 32'h0000_0000;

endpackage

// ---- ats_trigger_fabric.sv ----
// trigger routing and start-pulse fabric for converters and generators
//
// Behaviour
// RQ1 - each converter has four start inputs; any valid one starts conversion
// RQ2 - start 0 from pin, rising or falling edge, captured in converter domain
// RQ3 - start 1 takes the other converter's end-of-conversion chain output
// RQ4 - start 2 takes generator cycle trigger, synchronised, then edge captured
// RQ5 - timer-0 match outputs drive start 3 of both converters, converter domain
// RQ6 - fourth timer-0 match drives first generator sync and update permit
// RQ7 - sync pulse cascades from each generator to the next
// RQ8 - each timer-1 match feeds the matching generator's carrier input
// RQ9 - timer-1 pause comes from an external pin, halting carrier pulses
// RQ10 - timer-0 pause is NOR of all generator cycle trigger outputs
// RQ11 - software enables pause, loads match count, enables start 3 for decimation; code has only the start 3 enables, no pause enable or match count
// RQ12 - both timers' capture inputs see the converter start pulses
// RQ13 - serves four six-channel generators, two converters, two timers
// RQ14 - signals crossing generator and converter logic need synchronisation
// RQ15 - crossings use a two-stage synchroniser and edge detect, one-cycle pulse
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ats_trigger_fabric import ats_pkg::*; #(
	parameter int N_WG = 4 // RQ13
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [ATS_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ATS_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [ATS_NCONV-1:0] EXT_START_PIN,
	input wire logic [ATS_NCONV-1:0] CONV_EOC_CHAIN,
	input wire logic [N_WG-1:0] WG_CYCLE_OUT,
	input wire logic [ATS_NT0_MATCH-1:0] T0_MATCH,
	input wire logic [N_WG-1:0] T1_MATCH,
	input wire logic CARRIER_PAUSE_PIN,
	output logic [ATS_NCONV-1:0] CONV_START,
	output logic [N_WG-1:0] WG_SYNC_IN,
	output logic WG_TRANS_EN,
	output logic [N_WG-1:0] WG_CARRIER,
	output logic T0_PAUSE,
	output logic T1_PAUSE,
	output logic [ATS_NCONV-1:0] T0_CAPTURE,
	output logic [ATS_NCONV-1:0] T1_CAPTURE
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the cascade and carrier fan-out are sized for one to eight generators
	if (N_WG < 1 || N_WG > 8) begin : g_bad_wg
		$error("N_WG must lie between 1 and 8");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic aw_ready;
		logic w_ready;
		logic b_valid;
		logic [1:0] b_resp;
		logic ar_ready;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [ATS_ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [ATS_CTRL_W-1:0] ctrl;
		logic [ATS_NCONV-1:0] pin_s1;
		logic [ATS_NCONV-1:0] pin_s2;
		logic [ATS_NCONV-1:0] pin_prev;
		logic [ATS_NCONV-1:0] eoc_prev;
		logic wg_s1;
		logic wg_s2;
		logic wg_prev;
		logic t0_s1;
		logic t0_s2;
		logic t0_prev;
		logic [ATS_NCONV-1:0] conv_start;
		logic [ATS_NCONV*ATS_NSRC-1:0] last_src;
		logic [ATS_CNT_W-1:0] cnt0;
		logic [ATS_CNT_W-1:0] cnt1;
		logic [N_WG-1:0] wg_sync_in;
		logic wg_trans_en;
		logic [N_WG-1:0] wg_carrier;
		logic t0_pause;
		logic t1_pause;
		logic [ATS_NCONV-1:0] t0_cap;
		logic [ATS_NCONV-1:0] t1_cap;
	} ats_state_t;

	ats_state_t st_reg;
	ats_state_t st_next;
	logic [ATS_NCONV-1:0][ATS_NSRC-1:0] hit;
	logic [ATS_NCONV-1:0][ATS_NSRC-1:0] armed;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic addr_mapped(input logic [ATS_ADDR_W-1:0] a);
		return a < ATS_MAP_END;
	endfunction

	function automatic logic [31:0] rd_word(input logic [ATS_ADDR_W-1:0] a,
		input ats_state_t s);
		logic [ATS_ADDR_W-1:0] w;
		w = {a[ATS_ADDR_W-1:2], 2'h0};
		case (w)
			ATS_CTRL_OFS: rd_word = {22'h0, s.ctrl};
			ATS_STAT_OFS: rd_word = {24'h000000, s.last_src};
			ATS_CNT0_OFS: rd_word = {16'h0000, s.cnt0};
			ATS_CNT1_OFS: rd_word = {16'h0000, s.cnt1};
			default: rd_word = ATS_WORD_ZERO;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		hit = '0;
		armed = '0;

		// converter-domain captures: two flops then edge detect
		st_next.pin_s1 = EXT_START_PIN; // RQ2
		st_next.pin_s2 = st_reg.pin_s1; // RQ15
		st_next.pin_prev = st_reg.pin_s2;
		st_next.t0_s1 = |T0_MATCH; // RQ5
		st_next.t0_s2 = st_reg.t0_s1; // RQ15
		st_next.t0_prev = st_reg.t0_s2;
		// generator cycle triggers cross into converter logic
		st_next.wg_s1 = |WG_CYCLE_OUT; // RQ4 RQ14
		st_next.wg_s2 = st_reg.wg_s1; // RQ15
		st_next.wg_prev = st_reg.wg_s2;
		// the chain is already in this domain, so only an edge detect
		st_next.eoc_prev = CONV_EOC_CHAIN;

		for (int c = 0; c < ATS_NCONV; c++) begin
			if (st_reg.ctrl[ATS_FALL_LSB + c]) begin
				hit[c][ATS_SRC_PIN] = !st_reg.pin_s2[c] && st_reg.pin_prev[c]; // RQ2
			end else begin
				hit[c][ATS_SRC_PIN] = st_reg.pin_s2[c] && !st_reg.pin_prev[c]; // RQ2
			end
			// cross-coupled: each converter follows the other one
			hit[c][ATS_SRC_CHAIN] = CONV_EOC_CHAIN[ATS_NCONV-1-c] &&
				!st_reg.eoc_prev[ATS_NCONV-1-c]; // RQ3
			hit[c][ATS_SRC_WG] = st_reg.wg_s2 && !st_reg.wg_prev; // RQ4
			hit[c][ATS_SRC_T0] = st_reg.t0_s2 && !st_reg.t0_prev; // RQ5
			armed[c] = hit[c] & st_reg.ctrl[ATS_EN_LSB + c*ATS_NSRC +: ATS_NSRC];
			st_next.conv_start[c] = |armed[c]; // RQ1
			if (|armed[c]) begin
				st_next.last_src[c*ATS_NSRC +: ATS_NSRC] = armed[c];
			end
		end

		// one count per start pulse, wraps silently
		if (st_reg.conv_start[0]) begin
			st_next.cnt0 = st_reg.cnt0 + ATS_CNT_ONE;
		end
		if (st_reg.conv_start[1]) begin
			st_next.cnt1 = st_reg.cnt1 + ATS_CNT_ONE;
		end

		// generator and timer routing, one register stage each
		st_next.wg_sync_in[0] = T0_MATCH[ATS_T0_WG_MATCH]; // RQ6
		st_next.wg_trans_en = T0_MATCH[ATS_T0_WG_MATCH]; // RQ6
		for (int g = 1; g < N_WG; g++) begin
			st_next.wg_sync_in[g] = WG_CYCLE_OUT[g-1]; // RQ7
		end
		st_next.wg_carrier = T1_MATCH; // RQ8
		st_next.t1_pause = CARRIER_PAUSE_PIN; // RQ9
		st_next.t0_pause = ~|WG_CYCLE_OUT; // RQ10 RQ11
		st_next.t0_cap = st_reg.conv_start; // RQ12
		st_next.t1_cap = st_reg.conv_start; // RQ12

		// write channel: address and data in either order
		if (S_AXI_AWVALID && st_reg.aw_ready) begin
			st_next.waddr = S_AXI_AWADDR;
			st_next.aw_ready = 1'b0;
		end
		if (S_AXI_WVALID && st_reg.w_ready) begin
			st_next.wdata = S_AXI_WDATA;
			st_next.wstrb = S_AXI_WSTRB;
			st_next.w_ready = 1'b0;
		end
		if (!st_reg.aw_ready && !st_reg.w_ready && !st_reg.b_valid) begin
			st_next.b_valid = 1'b1;
			st_next.b_resp = addr_mapped(st_reg.waddr) ?
				ATS_RESP_OKAY : ATS_RESP_SLVERR;
			if ({st_reg.waddr[ATS_ADDR_W-1:2], 2'h0} == ATS_CTRL_OFS) begin
				if (st_reg.wstrb[0]) begin
					st_next.ctrl[ATS_LANE0_W-1:0] = st_reg.wdata[ATS_LANE0_W-1:0];
				end
				if (st_reg.wstrb[1]) begin
					st_next.ctrl[ATS_CTRL_W-1:ATS_LANE0_W] =
						st_reg.wdata[ATS_LANE0_W +: ATS_LANE1_W];
				end
			end
		end
		if (st_reg.b_valid && S_AXI_BREADY) begin
			st_next.b_valid = 1'b0;
			st_next.aw_ready = 1'b1;
			st_next.w_ready = 1'b1;
		end

		// read channel: one read in flight, answered one edge later
		if (S_AXI_ARVALID && st_reg.ar_ready) begin
			st_next.ar_ready = 1'b0;
			st_next.r_valid = 1'b1;
			st_next.r_data = rd_word(S_AXI_ARADDR, st_reg);
			st_next.r_resp = addr_mapped(S_AXI_ARADDR) ?
				ATS_RESP_OKAY : ATS_RESP_SLVERR;
		end
		if (st_reg.r_valid && S_AXI_RREADY) begin
			st_next.r_valid = 1'b0;
			st_next.ar_ready = 1'b1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_reg <= '0;
			st_reg.aw_ready <= 1'b1;
			st_reg.w_ready <= 1'b1;
			st_reg.ar_ready <= 1'b1;
			st_reg.ctrl <= ATS_CTRL_RST;
			// generators idle: timer-0 held paused until a cycle trigger
			st_reg.t0_pause <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign S_AXI_AWREADY = st_reg.aw_ready;
	assign S_AXI_WREADY = st_reg.w_ready;
	assign S_AXI_BVALID = st_reg.b_valid;
	assign S_AXI_BRESP = st_reg.b_resp;
	assign S_AXI_ARREADY = st_reg.ar_ready;
	assign S_AXI_RVALID = st_reg.r_valid;
	assign S_AXI_RDATA = st_reg.r_data;
	assign S_AXI_RRESP = st_reg.r_resp;
	assign CONV_START = st_reg.conv_start;
	assign WG_SYNC_IN = st_reg.wg_sync_in;
	assign WG_TRANS_EN = st_reg.wg_trans_en;
	assign WG_CARRIER = st_reg.wg_carrier;
	assign T0_PAUSE = st_reg.t0_pause;
	assign T1_PAUSE = st_reg.t1_pause;
	assign T0_CAPTURE = st_reg.t0_cap;
	assign T1_CAPTURE = st_reg.t1_cap;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_start0_rise: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ2
		(st_reg.ctrl[ATS_EN_LSB + ATS_SRC_PIN] && !st_reg.ctrl[ATS_FALL_LSB] &&
		$rose(EXT_START_PIN[0])) ##1
		(st_reg.ctrl[ATS_EN_LSB + ATS_SRC_PIN] && !st_reg.ctrl[ATS_FALL_LSB])[*2]
		|=> CONV_START[0])
		else $error("rising pin edge did not start converter 0");

	a_chain_cross: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ3
		(st_reg.ctrl[ATS_EN_LSB + ATS_NSRC + ATS_SRC_CHAIN] &&
		$rose(CONV_EOC_CHAIN[0])) |=> CONV_START[1])
		else $error("converter 0 chain did not start converter 1");

	a_wg_start: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ4
		(st_reg.ctrl[ATS_EN_LSB + ATS_NSRC + ATS_SRC_WG] &&
		$rose(|WG_CYCLE_OUT)) ##1
		st_reg.ctrl[ATS_EN_LSB + ATS_NSRC + ATS_SRC_WG][*2]
		|=> CONV_START[1])
		else $error("generator trigger did not start converter 1");

	a_t0_start: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ5
		(st_reg.ctrl[ATS_EN_LSB + ATS_SRC_T0] && $rose(|T0_MATCH)) ##1
		st_reg.ctrl[ATS_EN_LSB + ATS_SRC_T0][*2] |=> CONV_START[0])
		else $error("timer-0 match did not start converter 0");

	a_no_enable: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ1
		($past(st_reg.ctrl[ATS_EN_LSB +: ATS_NSRC]) == 4'h0) |-> !CONV_START[0])
		else $error("converter 0 started with all sources disabled");

	a_wg0_trigger: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ6
		$rose(T0_MATCH[ATS_T0_WG_MATCH]) |=> (WG_SYNC_IN[0] && WG_TRANS_EN))
		else $error("fourth timer-0 match not routed to generator 0");

	a_trans_follow: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ6
		##1 WG_TRANS_EN == $past(T0_MATCH[ATS_T0_WG_MATCH]))
		else $error("update permit does not follow the fourth match");

	a_sync_cascade: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ7
		$rose(WG_CYCLE_OUT[0]) |=> WG_SYNC_IN[1])
		else $error("sync not cascaded to generator 1");

	a_carrier_route: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ8
		##1 WG_CARRIER == $past(T1_MATCH))
		else $error("carrier does not follow timer-1 match");

	a_carrier_pause: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ9
		$fell(CARRIER_PAUSE_PIN) |=> !T1_PAUSE)
		else $error("timer-1 pause stuck after pin release");

	a_pause_follow: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ9
		##1 T1_PAUSE == $past(CARRIER_PAUSE_PIN))
		else $error("timer-1 pause does not follow the pause pin");

	a_t0_pause_nor: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ10
		(|WG_CYCLE_OUT) |=> !T0_PAUSE)
		else $error("timer-0 paused while a generator trigger is high");

	a_capture_dbg: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ12
		CONV_START[1] |=> (T0_CAPTURE[1] && T1_CAPTURE[1]))
		else $error("start pulse not seen on timer capture");

	a_cap_conv0: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ12
		CONV_START[0] |=> (T0_CAPTURE[0] && T1_CAPTURE[0]))
		else $error("converter 0 start not seen on timer capture");

	a_start_count: assert property (@(posedge CLK) disable iff (!RESET_N) // RQ15
		CONV_START[0] |=> st_reg.cnt0 == $past(st_reg.cnt0) + ATS_CNT_ONE)
		else $error("start counter missed a pulse");

endmodule

`default_nettype wire
